//--- dci_axi_master.sv
// AXI4-Lite master model for the core's register port.
// Assumes a registered slave; response ready lines stay high.
`timescale 1ns/1ps
module dci_axi_master (
   input  wire logic                  ref_clk_i,
   input  wire dci_pkg::dci_axi_rsp_t rsp_i,
   output      dci_pkg::dci_axi_req_t req_o
);
   import dci_pkg::*;
   // ****
   // Bus cycles
   // ****
   initial req_o = '{bready: 1'b1, rready: 1'b1, default: '0};

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      req_o.awvalid <= 1'b1;
      req_o.awaddr  <= a;
      req_o.wvalid  <= 1'b1;
      req_o.wdata   <= d;
      req_o.wstrb   <= 4'hf;
      do begin
         @(posedge ref_clk_i);
         if (rsp_i.awready === 1'b1) begin
            req_o.awvalid <= 1'b0;
            req_o.awaddr  <= ~a;
         end
         if (rsp_i.wready === 1'b1) begin
            req_o.wvalid <= 1'b0;
            req_o.wdata  <= ~d;
         end
      end while (rsp_i.bvalid !== 1'b1);
      r = rsp_i.bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      req_o.arvalid <= 1'b1;
      req_o.araddr  <= a;
      do begin
         @(posedge ref_clk_i);
         if (rsp_i.arready === 1'b1) begin
            req_o.arvalid <= 1'b0;
            req_o.araddr  <= ~a;
         end
      end while (rsp_i.rvalid !== 1'b1);
      d = rsp_i.rdata;
      @(posedge ref_clk_i);
   endtask : rd
endmodule : dci_axi_master

//--- dci_core.sv
// Executes the instruction subset issued through registers over AXI4-Lite.
// Assumes a synchronous master on ref_clk_i; the flag pin leaves the chip.
`timescale 1ns/1ps
module dci_core (
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire dci_pkg::dci_axi_req_t axi_req_i,
   output      dci_pkg::dci_axi_rsp_t axi_rsp_o,
   output      logic                  ext_flag_n_o
);
   import dci_pkg::*;

   typedef struct packed {
      dci_axi_rsp_t rsp;
      logic         aw_got;
      logic [7:0]   aw_addr;
      logic         w_got;
      logic [31:0]  w_data;
      dci_state_t   st;
      logic [15:0]  insn;
      logic [15:0]  word2;
      logic [15:0]  dmem;
      logic [15:0]  daddr;
      logic [1:0]   cyc;
      logic [31:0]  acc;
      logic [15:0]  pc;
      logic [4:0]   sp;
      logic [3:0]   data_page;
      logic [1:0]   io_page;
      logic [9:0]   repeat_counter;
      logic [2:0]   loop_length_count;
      logic         loop_on;
      logic [15:0]  loop_start;
      logic [9:0]   loop_left;
      logic [15:0]  modulo;
      logic         external_flag;
      logic         ext_flag_n;
      logic [NAUX-1:0][15:0] aux;
      logic [NSTK-1:0][15:0] stk;
      logic [NIO-1:0][15:0]  io;
   } dci_core_t;

   dci_core_t s;
   dci_core_t next_s;

   function automatic logic [1:0] cycles_of(input logic [15:0] a);
      cycles_of = (a >= EXT_BASE) ? 2'h2 : 2'h1; // [RQ23]
   endfunction : cycles_of

   function automatic logic [3:0] io_index(input logic [1:0] pg, input logic [15:0] i);
      io_index = {pg, i[1:0]}; // [RQ2] [RQ14]
   endfunction : io_index

   // ************************************************************
   // Bus slave and execution
   // ************************************************************
   logic [4:0]  op;
   logic [15:0] pc_next;
   logic        two_word;
   logic [31:0] rd;
   logic        rd_ok;

   always_comb begin
      op       = s.insn[15:11];
      two_word = (op == OP_CALL) || (op == OP_AUXL) || (op == OP_ORL) || (op == OP_PORT_WRITE_LONG);
      pc_next  = s.pc + (two_word ? 16'h0002 : 16'h0001); // [RQ5] [RQ16]
      rd_ok    = 1'b1;
      rd       = 32'h0000_0000;
      case (axi_req_i.araddr)
         A_INSN: rd = {s.word2, s.insn};
         A_DMEM: rd = {s.daddr, s.dmem};
         A_CTRL: rd = {30'h0000_0000, s.st};
         A_ACCH: rd = {16'h0000, s.acc[31:16]};
         A_ACCL: rd = {16'h0000, s.acc[15:0]};
         A_PC:   rd = {11'h000, s.sp, s.pc};
         A_STAT: rd = {25'h000_0000, s.ext_flag_n, s.io_page, s.data_page};
         A_LOOP: rd = {3'h0, s.loop_on, s.loop_length_count, 5'h00, s.loop_left,
                       s.repeat_counter};
         A_MODR: rd = {16'h0000, s.modulo};
         default: begin
            if (axi_req_i.araddr[7:5] == A_AUXB[7:5]) begin
               rd = {16'h0000, s.aux[axi_req_i.araddr[4:2]]};
            end else if (axi_req_i.araddr[7:6] == A_IOB[7:6]) begin
               rd = {16'h0000, s.io[axi_req_i.araddr[5:2]]};
            end else begin
               rd_ok = 1'b0;
            end
         end
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.rsp.awready = 1'b0;
      next_s.rsp.wready  = 1'b0;
      next_s.rsp.arready = 1'b0;
      if (s.rsp.bvalid && axi_req_i.bready) begin
         next_s.rsp.bvalid = 1'b0;
      end
      if (s.rsp.rvalid && axi_req_i.rready) begin
         next_s.rsp.rvalid = 1'b0;
      end
      if (axi_req_i.awvalid && !s.aw_got && !s.rsp.awready) begin
         next_s.rsp.awready = 1'b1;
         next_s.aw_got      = 1'b1;
         next_s.aw_addr     = axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && !s.w_got && !s.rsp.wready) begin
         next_s.rsp.wready = 1'b1;
         next_s.w_got      = 1'b1;
         next_s.w_data     = axi_req_i.wdata;
      end
      if (axi_req_i.arvalid && !s.rsp.rvalid && !s.rsp.arready) begin
         next_s.rsp.arready = 1'b1;
         next_s.rsp.rvalid  = 1'b1;
         next_s.rsp.rdata   = rd;
         next_s.rsp.rresp   = rd_ok ? RESP_OK : RESP_ERR;
      end
      // Register write, once address and data are both held
      if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
         next_s.aw_got     = 1'b0;
         next_s.w_got      = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp  = RESP_OK;
         case (s.aw_addr)
            A_INSN: begin
               if (s.st == ST_IDLE) begin
                  next_s.insn  = s.w_data[15:0];
                  next_s.word2 = s.w_data[31:16];
               end
            end
            A_DMEM: begin
               next_s.dmem  = s.w_data[15:0];
               next_s.daddr = s.w_data[31:16];
            end
            A_CTRL: begin
               if (s.w_data[0] && s.st == ST_IDLE) begin
                  next_s.st = ST_EXEC;
               end
            end
            A_PC: begin
               next_s.pc = s.w_data[15:0];
               next_s.sp = s.w_data[20:16];
            end
            default: begin
               if (s.aw_addr[7:5] == A_AUXB[7:5]) begin
                  next_s.aux[s.aw_addr[4:2]] = s.w_data[15:0];
               end else if (s.aw_addr[7:6] == A_IOB[7:6]) begin
                  next_s.io[s.aw_addr[5:2]] = s.w_data[15:0];
               end else if (s.aw_addr != A_STAT && s.aw_addr != A_LOOP
                            && s.aw_addr != A_ACCH && s.aw_addr != A_ACCL
                            && s.aw_addr != A_MODR) begin
                  next_s.rsp.bresp = RESP_ERR;
               end
            end
         endcase
      end
      // Execute one instruction
      case (s.st)
         ST_IDLE: begin
         end
         ST_EXEC: begin
            next_s.pc  = pc_next;
            next_s.st  = ST_WAIT;
            next_s.cyc = 2'h1;
            case (op)
               OP_CALL: begin
                  next_s.stk[s.sp] = s.pc + 16'h0001; // [RQ1]
                  next_s.sp        = s.sp + 5'h01;
                  next_s.pc        = s.word2;
                  next_s.cyc       = 2'h3;
               end
               OP_IN:    next_s.dmem = s.io[io_index(s.io_page, s.insn)]; // [RQ2]
               OP_LACH:  begin
                  next_s.acc = {s.dmem, 16'h0000}; // [RQ3]
                  next_s.cyc = cycles_of(s.daddr);
               end
               OP_AUXS:  next_s.aux[s.insn[9:7]] = {9'h000, s.insn[6:0]}; // [RQ4]
               OP_AUXL:  begin
                  next_s.aux[s.insn[9:7]] = s.word2; // [RQ5]
                  next_s.cyc = 2'h2;
               end
               OP_DPM:   begin
                  next_s.data_page = s.dmem[3:0]; // [RQ6]
                  next_s.cyc = cycles_of(s.daddr);
               end
               OP_DPI:   next_s.data_page = s.insn[3:0]; // [RQ6]
               OP_IOPM:  begin
                  next_s.io_page = s.dmem[5:4]; // [RQ7]
                  next_s.cyc = cycles_of(s.daddr);
               end
               OP_IOPI:  next_s.io_page = s.insn[1:0]; // [RQ8]
               OP_LOOP:  begin
                  next_s.repeat_counter    = s.dmem[9:0]; // [RQ9]
                  next_s.loop_length_count = s.insn[10:8];
                  next_s.loop_on           = 1'b1; // [RQ10]
                  next_s.loop_start        = pc_next;
                  next_s.loop_left         = s.dmem[9:0];
                  next_s.cyc = cycles_of(s.daddr);
               end
               OP_MOD:   begin
                  next_s.modulo = s.dmem; // [RQ12]
                  next_s.cyc = cycles_of(s.daddr);
               end
               OP_ORL:   begin
                  next_s.acc[31:16] = s.acc[31:16] | s.word2; // [RQ13]
                  next_s.cyc = 2'h2;
               end
               OP_OUT:   next_s.io[io_index(s.io_page, s.insn)] = s.dmem; // [RQ14]
               OP_OUTS:  next_s.io[io_index(s.io_page, s.insn)][6:0] = s.insn[8:2]; // [RQ15] [RQ24]
               OP_PORT_WRITE_LONG:  begin
                  next_s.io[io_index(s.io_page, s.insn)] = s.word2; // [RQ16]
                  next_s.cyc = 2'h2;
               end
               OP_POP:   begin
                  next_s.sp   = s.sp - 5'h01; // [RQ17]
                  next_s.dmem = s.stk[5'(s.sp - 5'h01)];
                  next_s.cyc  = cycles_of(s.daddr);
               end
               OP_POP_TO_ACC_HIGH:  begin
                  next_s.sp         = s.sp - 5'h01; // [RQ18]
                  next_s.acc[31:16] = s.stk[5'(s.sp - 5'h01)];
               end
               OP_POP_TO_ACC_LOW:  begin
                  next_s.sp        = s.sp - 5'h01; // [RQ19]
                  next_s.acc[15:0] = s.stk[5'(s.sp - 5'h01)];
               end
               OP_XFCLR: begin
                  next_s.external_flag = 1'b0; // [RQ20]
                  next_s.ext_flag_n    = 1'b1;
               end
               OP_XFSET: begin
                  next_s.external_flag = 1'b1;
                  next_s.ext_flag_n    = 1'b0;
               end
               OP_SAH:   begin
                  next_s.dmem = s.acc[31:16]; // [RQ21]
                  next_s.cyc  = cycles_of(s.daddr);
               end
               OP_SAL:   begin
                  next_s.dmem = s.acc[15:0]; // [RQ22]
                  next_s.cyc  = cycles_of(s.daddr);
               end
               default:  next_s.cyc = 2'h1;
            endcase
            // Loop wrap: software keeps branches out of the body [RQ11]
            if (s.loop_on && op != OP_LOOP
                && pc_next == s.loop_start + {13'h0000, s.loop_length_count} + 16'h0001) begin
               if (s.loop_left != 10'h000) begin
                  next_s.pc        = s.loop_start; // [RQ10]
                  next_s.loop_left = s.loop_left - 10'h001;
               end else begin
                  next_s.loop_on = 1'b0;
               end
            end
         end
         ST_WAIT: begin
            next_s.cyc = s.cyc - 2'h1;
            if (s.cyc == 2'h1) begin
               next_s.st = ST_IDLE;
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s <= '{rsp: '0, aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0, w_data: 32'h0,
                st: ST_IDLE, insn: 16'h0, word2: 16'h0, dmem: 16'h0, daddr: 16'h0,
                cyc: 2'h0, acc: 32'h0, pc: 16'h0, sp: 5'h00, data_page: 4'h0,
                io_page: 2'h0, repeat_counter: 10'h0, loop_length_count: 3'h0,
                loop_on: 1'b0, loop_start: 16'h0, loop_left: 10'h0, modulo: 16'h0,
                external_flag: 1'b0, ext_flag_n: 1'b1,
                aux: '0, stk: '0, io: '0};
      end else begin
         s <= next_s;
      end
   end

   assign axi_rsp_o    = s.rsp;
   assign ext_flag_n_o = s.ext_flag_n;

   // ************************************************************
   // Checks
   // ************************************************************
   a_call_timing: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ1]
      (s.st == ST_EXEC && op == OP_CALL) |=> (s.pc == $past(s.word2)) ##0
      (s.st == ST_WAIT)[*3] ##1 (s.st == ST_IDLE))
      else $error("call timing wrong");
   a_call_push: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ1]
      (s.st == ST_EXEC && op == OP_CALL) |=> (s.sp == $past(s.sp) + 5'h01))
      else $error("call push wrong");
   a_lach_load: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ3]
      (s.st == ST_EXEC && op == OP_LACH) |=> (s.acc == {$past(s.dmem), 16'h0000}))
      else $error("high load wrong");
   a_ext_extra: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ23]
      (s.st == ST_EXEC && op == OP_SAH && s.daddr >= EXT_BASE) |=> s.cyc == 2'h2)
      else $error("external cycle missing");
   a_aux_short: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ4]
      (s.st == ST_EXEC && op == OP_AUXS) |=> s.aux[$past(s.insn[9:7])][15:7] == 9'h000)
      else $error("short aux upper bits");
   a_pc_long: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ16]
      (s.st == ST_EXEC && op == OP_PORT_WRITE_LONG && !s.loop_on) |=> s.pc == $past(s.pc) + 16'h0002)
      else $error("long output pc");
   a_pop_high: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ18]
      (s.st == ST_EXEC && op == OP_POP_TO_ACC_HIGH) |=> s.sp == $past(s.sp) - 5'h01)
      else $error("pop stack pointer");
   a_flag_pin: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ20]
      ext_flag_n_o == !s.external_flag)
      else $error("flag pin not inverted");
   a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ20]
      (s.st == ST_EXEC && op == OP_XFCLR) |=> (ext_flag_n_o == 1'b1 && !s.external_flag))
      else $error("flag clear wrong");
   a_or_high: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [RQ13]
      (s.st == ST_EXEC && op == OP_ORL) |=> s.acc[15:0] == $past(s.acc[15:0]))
      else $error("or touched low half");
   c_call: cover property (@(posedge ref_clk_i) s.st == ST_EXEC && op == OP_CALL);
   c_loop_wrap: cover property (@(posedge ref_clk_i) s.loop_on && s.loop_left == 10'h000);
   c_ext: cover property (@(posedge ref_clk_i) s.st == ST_WAIT && s.cyc == 2'h2);
endmodule : dci_core

//--- dci_pkg.sv
// Constants, opcodes and carrier types for the instruction execution subset.
// Assumes one 50 MHz clock and an AXI4-Lite master that drives the register file.
// Summary of operation
// [RQ1] Direct call pushes pc+1, bumps stack pointer, jumps; two words, three cycles.
// [RQ2] Port input reads I/O register at page.port into data memory operand.
// [RQ3] High load puts operand in acc high, clears low; 1 or 2 cycles.
// [RQ4] Short aux load writes 7-bit immediate, clears upper nine bits.
// [RQ5] Long aux load writes second word into aux register; pc+2, two cycles.
// [RQ6] Data page loads set 4-bit page from operand low bits or immediate.
// [RQ7] Memory I/O page load copies operand bits 5:4 into I/O page.
// [RQ8] Immediate I/O page load writes 2-bit immediate into I/O page.
// [RQ9] Loop setup loads repeat counter from operand bits 9:0, length from field.
// [RQ10] Loop body of length+1 words repeats count+1 times, no overhead.
// [RQ11] Software puts no branch or call inside a loop body.
// [RQ12] Modulo load copies operand into modulo register; 1 or 2 cycles.
// [RQ13] Long OR merges immediate into acc high; two words, two cycles.
// [RQ14] Port output writes operand to I/O register at page.port.
// [RQ15] Short port output writes 7-bit immediate into I/O register low bits.
// [RQ16] Long port output writes second word to I/O register; pc+2, two cycles.
// [RQ17] Pop to memory decrements stack pointer then stores that entry.
// [RQ18] Pop high decrements stack pointer, loads entry into acc high.
// [RQ19] Pop low decrements stack pointer, loads entry into acc low.
// [RQ20] Flag clear resets flag; active-low flag pin goes high.
// [RQ21] High store writes acc high to operand; 1 or 2 cycles.
// [RQ22] Low store writes acc low to operand; 1 or 2 cycles.
// [RQ23] Extra cycle chosen when operand address is external data memory; OP_IN and OP_OUT always take one cycle.
// [RQ24] Short port writes keep I/O register upper bits.
package dci_pkg;
   // Opcodes, placed in instruction bits 15:11
   localparam logic [4:0] OP_CALL  = 5'h01;
   localparam logic [4:0] OP_IN    = 5'h02;
   localparam logic [4:0] OP_LACH  = 5'h03;
   localparam logic [4:0] OP_AUXS  = 5'h04;
   localparam logic [4:0] OP_AUXL  = 5'h05;
   localparam logic [4:0] OP_DPM   = 5'h06;
   localparam logic [4:0] OP_DPI   = 5'h07;
   localparam logic [4:0] OP_IOPM  = 5'h08;
   localparam logic [4:0] OP_IOPI  = 5'h09;
   localparam logic [4:0] OP_LOOP  = 5'h0a;
   localparam logic [4:0] OP_MOD   = 5'h0b;
   localparam logic [4:0] OP_ORL   = 5'h0c;
   localparam logic [4:0] OP_OUT   = 5'h0d;
   localparam logic [4:0] OP_OUTS  = 5'h0e;
   localparam logic [4:0] OP_PORT_WRITE_LONG  = 5'h0f;
   localparam logic [4:0] OP_POP   = 5'h10;
   localparam logic [4:0] OP_POP_TO_ACC_HIGH  = 5'h11;
   localparam logic [4:0] OP_POP_TO_ACC_LOW  = 5'h12;
   localparam logic [4:0] OP_XFCLR = 5'h13;
   localparam logic [4:0] OP_SAH   = 5'h14;
   localparam logic [4:0] OP_SAL   = 5'h15;
   localparam logic [4:0] OP_XFSET = 5'h16;
   // Register byte addresses
   localparam logic [7:0] A_INSN   = 8'h00;
   localparam logic [7:0] A_DMEM   = 8'h04;
   localparam logic [7:0] A_CTRL   = 8'h08;
   localparam logic [7:0] A_ACCH   = 8'h0c;
   localparam logic [7:0] A_ACCL   = 8'h10;
   localparam logic [7:0] A_PC     = 8'h14;
   localparam logic [7:0] A_STAT   = 8'h18;
   localparam logic [7:0] A_LOOP   = 8'h1c;
   localparam logic [7:0] A_MODR   = 8'h20;
   localparam logic [7:0] A_AUXB   = 8'h40;
   localparam logic [7:0] A_IOB    = 8'h80;
   // Field layout and sizes
   localparam int IOP_W   = 2;
   localparam int PORT_W  = 4;
   localparam int NAUX    = 8;
   localparam int NSTK    = 32;
   localparam int NIO     = 16;
   localparam logic [15:0] EXT_BASE = 16'h1000;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_WAIT = 2'b10
   } dci_state_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } dci_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dci_axi_rsp_t;
endpackage : dci_pkg

//--- tb.sv
// Self-checking bench for the instruction execution core.
// Assumes dci_axi_master drives the register port; results are read back.
`timescale 1ns/1ps
module tb;
   import dci_pkg::*;
   logic         ref_clk_i = 1'b0;
   logic         sys_rst_i = 1'b1;
   dci_axi_req_t req;
   dci_axi_rsp_t rsp;
   logic         ext_flag_n_o;
   int           n_fail = 0;
   int           checks = 0;
   logic [33:0]  exp_q[$];
   logic [31:0]  msk_q[$];
   logic [33:0]  me;
   logic [31:0]  mm, dd, rnd = 32'h7f3417d7;
   logic [15:0]  r, k, t, u;
   logic [7:0]   io;
   logic [15:0]  lpc [4] = '{16'h0202, 16'h0201, 16'h0202, 16'h0203};

   always #10 ref_clk_i = ~ref_clk_i;

   dci_core dut (
      .ref_clk_i   (ref_clk_i),
      .sys_rst_i   (sys_rst_i),
      .axi_req_i   (req),
      .axi_rsp_o   (rsp),
      .ext_flag_n_o(ext_flag_n_o)
   );
   dci_axi_master mst (.ref_clk_i(ref_clk_i), .rsp_i(rsp), .req_o(req));

   // ****
   // Helpers
   // ****
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic nx();
      rnd = lfsr(rnd);
      r   = rnd[15:0];
      k   = rnd[31:16];
   endtask : nx

   task automatic bad(input logic [33:0] g, input logic [33:0] e);
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
   endtask : bad

   task automatic complete_run();
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic note(input logic [33:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
   endtask : note

   task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] rs;
      mst.wr(a, d, rs);
      checks++;
      if (rs !== er) bad({32'h0, rs}, {32'h0, er});
   endtask : w

   task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      note({RESP_OK, e}, m);
      mst.rd(a, dd);
   endtask : chk

   task automatic ex(input logic [31:0] ins, input logic [31:0] op);
      int n;
      w(A_INSN, ins, RESP_OK);
      w(A_DMEM, op, RESP_OK);
      w(A_CTRL, 32'h1, RESP_OK);
      n = 0;
      do begin
         note({RESP_OK, 32'h0}, 32'h0);
         mst.rd(A_CTRL, dd);
         n++;
      end while (dd[1:0] !== 2'b00 && n < 40);
      if (dd[1:0] !== 2'b00) bad(34'(n), 34'h0);
   endtask : ex

   // ****
   // Read result monitor
   // ****
   always @(posedge ref_clk_i) begin
      if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
         me = exp_q.pop_front();
         mm = msk_q.pop_front();
         if (mm != 32'h0) checks++;
         if (rsp.rresp !== me[33:32] || ((rsp.rdata ^ me[31:0]) & mm) !== 32'h0)
            bad({rsp.rresp, rsp.rdata}, me);
      end
   end

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail++;
      complete_run();
   end

   // ****
   // Scenarios
   // ****
   initial begin
      repeat (10) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      chk(A_STAT, 32'h40, 32'h7f);
      note({RESP_ERR, 32'h0}, '1);
      mst.rd(8'h24, dd);
      w(8'hfc, 32'h1, RESP_ERR);
      for (int i = 0; i < 2; i++) begin
         nx();
         ex({16'h0, OP_DPI, 7'h0, r[3:0]}, 0);
         ex({16'h0, OP_IOPI, 9'h0, r[5:4]}, 0);
         chk(A_STAT, {25'h0, 1'b1, r[5:4], r[3:0]}, 32'h7f);
         ex({16'h0, OP_DPM, 11'h0}, {i[0] ? 16'h1000 : 16'h0020, k});
         ex({16'h0, OP_IOPM, 11'h0}, {i[0] ? 16'h0030 : 16'h1010, r});
         chk(A_STAT, {25'h0, 1'b1, r[5:4], k[3:0]}, 32'h7f);
      end
      w(A_PC, {11'h0, 5'd3, 16'h0100}, RESP_OK);
      nx();
      t = r;
      u = k;
      ex({t, OP_CALL, 11'h0}, 0);
      chk(A_PC, {11'h0, 5'd4, t}, 32'h001fffff);
      ex({16'h0, OP_POP_TO_ACC_LOW, 11'h0}, 0);
      chk(A_ACCL, 32'h0101, 32'hffff);
      ex({u, OP_CALL, 11'h0}, 0);
      ex({16'h0, OP_POP_TO_ACC_HIGH, 11'h0}, 0);
      chk(A_ACCH, {16'h0, t + 16'h2}, 32'hffff);
      chk(A_PC, {11'h0, 5'd3, u + 16'h1}, 32'h001fffff);
      nx();
      ex({r, OP_ORL, 11'h0}, 0);
      chk(A_ACCH, {16'h0, (t + 16'h2) | r}, 32'hffff);
      chk(A_ACCL, 32'h0101, 32'hffff);
      chk(A_PC, {16'h0, u + 16'h3}, 32'hffff);
      ex({16'h0, OP_LACH, 11'h0}, {16'h1000, k});
      w(A_ACCH, 32'h0, RESP_OK);
      chk(A_ACCH, {16'h0, k}, 32'hffff);
      chk(A_ACCL, 32'h0, 32'hffff);
      w(A_PC, {11'h0, 5'd4, 16'h0300}, RESP_OK);
      ex({16'h0, OP_POP, 11'h0}, {16'h0040, r});
      chk(A_DMEM, {16'h0, t + 16'h2}, 32'hffff);
      w(A_PC, {11'h0, 5'd4, 16'h0300}, RESP_OK);
      ex({16'h0, OP_POP_TO_ACC_LOW, 11'h0}, 0);
      ex({16'h0, OP_SAH, 11'h0}, {16'h1000, r});
      chk(A_DMEM, {16'h0, k}, 32'hffff);
      ex({16'h0, OP_SAL, 11'h0}, {16'h0041, r});
      chk(A_DMEM, {16'h0, t + 16'h2}, 32'hffff);
      nx();
      w(A_AUXB + 8'h14, 32'hffff, RESP_OK);
      ex({16'h0, OP_AUXS, 1'b0, 3'd5, r[6:0]}, 0);
      chk(A_AUXB + 8'h14, {25'h0, r[6:0]}, '1);
      w(A_PC, 32'h0003_0400, RESP_OK);
      ex({k, OP_AUXL, 1'b0, 3'd2, 7'h0}, 0);
      chk(A_AUXB + 8'h08, {16'h0, k}, '1);
      chk(A_PC, 32'h0003_0402, 32'h001fffff);
      ex({16'h0, OP_MOD, 11'h0}, {16'h1000, 6'h0, r[9:0]});
      chk(A_MODR, {22'h0, r[9:0]}, '1);
      ex({16'h0, OP_IOPI, 9'h0, 2'd2}, 0);
      for (int p = 0; p < 4; p++) begin
         nx();
         io = A_IOB + {2'd2, p[1:0], 2'b00};
         w(io, 32'hffff, RESP_OK);
         ex({16'h0, OP_OUTS, 2'b0, r[6:0], p[1:0]}, 0);
         chk(io, {16'h0, 9'h1ff, r[6:0]}, 32'hffff);
         ex({16'h0, OP_OUT, 9'h0, p[1:0]}, {16'h0080, k});
         chk(io, {16'h0, k}, 32'hffff);
         ex({16'h0, OP_IN, 9'h0, p[1:0]}, {16'h0081, ~k});
         chk(A_DMEM, {16'h0, k}, 32'hffff);
         ex({r, OP_PORT_WRITE_LONG, 9'h0, p[1:0]}, 0);
         chk(io, {16'h0, r}, 32'hffff);
      end
      ex({16'h0, OP_XFSET, 11'h0}, 0);
      checks++;
      if (ext_flag_n_o !== 1'b0) bad({33'h0, ext_flag_n_o}, 34'h0);
      ex({16'h0, OP_XFCLR, 11'h0}, 0);
      checks++;
      if (ext_flag_n_o !== 1'b1) bad({33'h0, ext_flag_n_o}, 34'h1);
      chk(A_STAT, 32'h40, 32'h40);
      w(A_PC, 32'h0003_0200, RESP_OK);
      nx();
      ex({16'h0, OP_LOOP, 3'd1, 8'h0}, {16'h0010, r[15:10], 10'h001});
      chk(A_LOOP, 32'h0200_0001, 32'h0e0003ff);
      for (int i = 0; i < 4; i++) begin
         ex({16'h0, OP_DPI, 11'h005}, 0); // Body holds no branch or call
         chk(A_PC, {16'h0, lpc[i]}, 32'hffff);
      end
      complete_run();
   end
endmodule : tb
